//--- include/mfcr_map.svh
// Register offsets, field positions, reset values and fault codes of the fault checker
`ifndef MFCR_MAP_SVH
`define MFCR_MAP_SVH

// Register byte offsets on the APB
`define MFCR_OFF_DFSR 12'h000
`define MFCR_OFF_IFSR 12'h004
`define MFCR_OFF_FAR 12'h008
`define MFCR_OFF_DACR 12'h00C
`define MFCR_OFF_CTRL 12'h010

// Control register bit positions
`define MFCR_CTRL_MMU_EN 0
`define MFCR_CTRL_ALIGN_EN 1
`define MFCR_CTRL_SYS_PROT 2
`define MFCR_CTRL_ROM_PROT 3
`define MFCR_CTRL_W 4

// Fault status register field positions
`define MFCR_FSR_STAT_LSB 0
`define MFCR_FSR_DOM_LSB 4
`define MFCR_FSR_W 8

// Reset values
`define MFCR_RST_CTRL 4'h0
`define MFCR_RST_DACR 32'h0000_0000
`define MFCR_RST_FSR 8'h00
`define MFCR_RST_FAR 32'h0000_0000

// Fault status codes
`define MFCR_ST_ALIGN 4'h1
`define MFCR_ST_XT_L1 4'hC
`define MFCR_ST_XT_L2 4'hE
`define MFCR_ST_TR_SEC 4'h5
`define MFCR_ST_TR_PAGE 4'h7
`define MFCR_ST_DOM_SEC 4'h9
`define MFCR_ST_DOM_PAGE 4'hB
`define MFCR_ST_PERM_SEC 4'hD
`define MFCR_ST_PERM_PAGE 4'hF
`define MFCR_ST_XA_SEC 4'h8
`define MFCR_ST_XA_PAGE 4'hA

// Descriptor type codes in bits [1:0]
`define MFCR_DESC_FAULT 2'h0
`define MFCR_L1_SECTION 2'h2

// Domain and permission field codes
`define MFCR_DOM_CLIENT 2'h1
`define MFCR_DOM_MANAGER 2'h3
`define MFCR_AP_NONE 2'h0
`define MFCR_AP_PRIV 2'h1
`define MFCR_AP_USER_RO 2'h2

// Access sizes
`define MFCR_SZ_HALF 2'h1
`define MFCR_SZ_WORD 2'h2

// 1 KB block split of an address, and the last word offset in a block
`define MFCR_KB_LSB 10
`define MFCR_KB_LAST_WORD 10'h3FC

`endif

//--- include/mfcr_pkg.sv
// Types shared by the fault checker and its users
`default_nettype none
package mfcr_pkg;

	// One access presented for checking, with what the table walk returned
	typedef struct packed {
		logic [31:0] modified_virtual_address;
		logic is_fetch;
		logic is_pf_op;
		logic [1:0] size;
		logic is_write;
		logic is_user;
		logic burst_first;
		logic burst_more;
		logic l1_walk_abort;
		logic [1:0] l1_type;
		logic [3:0] l1_domain;
		logic [1:0] l1_ap;
		logic l2_walk_abort;
		logic [1:0] l2_type;
		logic [1:0] l2_ap;
	} mfcr_req_s;

	// Verdict on a checked access
	typedef struct packed {
		logic abort;
		logic bus_ok;
		logic [3:0] status;
		logic [3:0] domain;
	} mfcr_rsp_s;

	// External abort reported by the bus side for a granted data transfer
	typedef struct packed {
		logic is_section;
		logic [3:0] domain;
		logic [31:0] start_mva;
		logic [31:0] abort_mva;
		logic [31:0] last_mva;
	} mfcr_xab_s;

endpackage

`default_nettype wire

//--- core/mfcr_core.sv
// Access fault checker with fault status, fault address and domain control registers
//
// Summary of operation
// - Data abort stores four-bit status and domain in the data fault status register
// - Fetch abort stores four-bit status and domain in the instruction fault status register
// - Fault address captures data abort address; fetch faults leave it alone
// - One fault encoded, priority alignment, walk abort, translation, domain, permission, external
// - Alignment fault reports 0b0001 with invalid domain; never on fetches
// - Walk external abort: 0b1100 invalid domain first level, 0b1110 valid second level
// - Domain 0b1001/0b1011, permission 0b1101/0b1111, all with valid domain
// - Domain field is left stale when no valid domain was read
// - Masked faults are not remembered; a retry re-checks from scratch
// - Explicit prefetch operations may update the instruction fault status register
// - Multi-word transfers capture the address of the first aborted word
// - Multi-word external abort captures last word before 1 KB boundary or last word
// - Sixteen domains, two bits each, in one 32-bit domain control register
// - Domain code 00 or 10 faults every access
// - Client codes check permissions; manager bypasses them
// - Permission 00: none, read-only with one protect bit, both bits unpredictable
// - Permission 01 privileged only, 10 user read-only, 11 full access
// - Misaligned word or halfword data faults when alignment check enabled
// - Alignment fault aborts at once, skipping all other checks
// - First-level descriptor type 00 gives section translation fault
// - Second-level descriptor type 00 gives page translation fault
// - Translation checks need the MMU enable; alignment only its own enable
// - A faulting access is kept off the bus and aborted to the core
//
// Added by the designer: the address map and the APB register port.
`timescale 1ns/1ps
`default_nettype none
`include "mfcr_map.svh"

module mfcr_core
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic chk_valid,
	input wire mfcr_pkg::mfcr_req_s chk_req,
	output logic rsp_valid,
	output mfcr_pkg::mfcr_rsp_s rsp,
	input wire logic xab_valid,
	input wire mfcr_pkg::mfcr_xab_s xab
);

	logic [31:0] prdata_ff;
	logic pready_ff;
	logic pslverr_ff;
	logic rsp_valid_ff;
	mfcr_pkg::mfcr_rsp_s rsp_ff;
	logic [`MFCR_CTRL_W-1:0] ctrl_ff;
	logic [31:0] dacr_ff;
	logic [`MFCR_FSR_W-1:0] dfsr_ff;
	logic [`MFCR_FSR_W-1:0] ifsr_ff;
	logic [31:0] fault_addr_reg_ff;
	logic burst_aborted_ff;

	// Combinational check results
	logic chk_abort;
	logic [3:0] chk_status;
	logic chk_dom_valid;
	logic chk_capture;
	logic [31:0] xab_addr;
	logic apb_wr;
	logic apb_setup;
	logic wr_ctrl;
	logic wr_dacr;
	logic wr_dfsr;
	logic wr_ifsr;
	logic wr_far;

	assign prdata = prdata_ff;
	assign pready = pready_ff;
	assign pslverr = pslverr_ff;
	assign rsp_valid = rsp_valid_ff;
	assign rsp = rsp_ff;

	// Two-bit domain code for a domain number
	// Domain n sits at bits 2n+1:2n, so the index is the domain number doubled
	function automatic logic [1:0] dom_code(input logic [31:0] dacr, input logic [3:0] dom);
		dom_code = dacr[{dom, 1'b0} +: 2];
	endfunction

	// Whether an access is allowed by a permission field and the two protect bits
	// Both protect bits set is undefined for the system; here it simply denies
	function automatic logic perm_ok(input logic [1:0] ap, input logic sys_p, input logic rom_p,
		input logic user, input logic write);
		case (ap)
			`MFCR_AP_NONE:
				perm_ok = (sys_p ^ rom_p) && !write;
			`MFCR_AP_PRIV:
				perm_ok = !user;
			`MFCR_AP_USER_RO:
				perm_ok = !user || !write;
			default:
				perm_ok = 1'b1;
		endcase
	endfunction

	// Misalignment of a data access for its size
	// Byte accesses never fault, whatever the low address bits hold
	function automatic logic misaligned(input logic [1:0] size, input logic [1:0] lsb);
		case (size)
			`MFCR_SZ_HALF:
				misaligned = lsb[0];
			`MFCR_SZ_WORD:
				misaligned = |lsb;
			default:
				misaligned = 1'b0;
		endcase
	endfunction

	// Address kept for a multi-word external abort
	// Only two blocks are told apart; a transfer is assumed to cross at most one boundary
	function automatic logic [31:0] xab_far(input mfcr_pkg::mfcr_xab_s x);
		logic early;
		logic same_blk;
		early = x.abort_mva[31:`MFCR_KB_LSB] == x.start_mva[31:`MFCR_KB_LSB];
		same_blk = x.last_mva[31:`MFCR_KB_LSB] == x.start_mva[31:`MFCR_KB_LSB];
		if (early && !same_blk)
			xab_far = {x.start_mva[31:`MFCR_KB_LSB], `MFCR_KB_LAST_WORD};
		else
			xab_far = x.last_mva;
	endfunction

	// Priority encoder over all fault sources but the bus external abort; only the winner leaves this block
	always_comb
	begin
		logic sect;
		logic [1:0] dc;
		logic [1:0] ap_sel;
		sect = chk_req.l1_type == `MFCR_L1_SECTION;
		dc = dom_code(dacr_ff, chk_req.l1_domain);
		ap_sel = sect ? chk_req.l1_ap : chk_req.l2_ap;
		// Default is an abort; pass paths clear it, so every path drives all three results
		chk_abort = 1'b1;
		chk_status = `MFCR_ST_ALIGN;
		chk_dom_valid = 1'b0;
		if (ctrl_ff[`MFCR_CTRL_ALIGN_EN] && !chk_req.is_fetch && !chk_req.is_pf_op
			&& misaligned(chk_req.size, chk_req.modified_virtual_address[1:0]))
		begin
			chk_status = `MFCR_ST_ALIGN;
			chk_dom_valid = 1'b0;
		end
		else if (!ctrl_ff[`MFCR_CTRL_MMU_EN])
		begin
			chk_abort = 1'b0;
		end
		else if (chk_req.l1_walk_abort)
		begin
			chk_status = `MFCR_ST_XT_L1;
			chk_dom_valid = 1'b0;
		end
		else if (chk_req.l1_type == `MFCR_DESC_FAULT)
		begin
			chk_status = `MFCR_ST_TR_SEC;
			chk_dom_valid = 1'b0;
		end
		else if (!sect && chk_req.l2_walk_abort)
		begin
			chk_status = `MFCR_ST_XT_L2;
			chk_dom_valid = 1'b1;
		end
		else if (!sect && chk_req.l2_type == `MFCR_DESC_FAULT)
		begin
			chk_status = `MFCR_ST_TR_PAGE;
			chk_dom_valid = 1'b1;
		end
		else if (dc != `MFCR_DOM_CLIENT && dc != `MFCR_DOM_MANAGER)
		begin
			chk_status = sect ? `MFCR_ST_DOM_SEC : `MFCR_ST_DOM_PAGE;
			chk_dom_valid = 1'b1;
		end
		else if (dc == `MFCR_DOM_CLIENT && !perm_ok(ap_sel, ctrl_ff[`MFCR_CTRL_SYS_PROT],
			ctrl_ff[`MFCR_CTRL_ROM_PROT], chk_req.is_user, chk_req.is_write))
		begin
			chk_status = sect ? `MFCR_ST_PERM_SEC : `MFCR_ST_PERM_PAGE;
			chk_dom_valid = 1'b1;
		end
		else
		begin
			chk_abort = 1'b0;
		end
	end

	// Later words of an already aborted burst do not overwrite the first capture
	// A masked lower fault is never stored, so a retry reports it afresh
	assign chk_capture = chk_valid && chk_abort && !(chk_req.burst_more && burst_aborted_ff);
	assign xab_addr = xab_far(xab);

	// APB decode: a write takes effect in the access phase
	// Gating with pready keeps a stray access phase from writing anything
	assign apb_setup = psel && !penable;
	assign apb_wr = psel && penable && pready_ff && pwrite;
	assign wr_ctrl = apb_wr && paddr == `MFCR_OFF_CTRL;
	assign wr_dacr = apb_wr && paddr == `MFCR_OFF_DACR;
	assign wr_dfsr = apb_wr && paddr == `MFCR_OFF_DFSR;
	assign wr_ifsr = apb_wr && paddr == `MFCR_OFF_IFSR;
	assign wr_far = apb_wr && paddr == `MFCR_OFF_FAR;

	// APB answer: ready and read data are prepared in the setup cycle so they come from flops
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			pready_ff <= 1'b0;
			pslverr_ff <= 1'b0;
			prdata_ff <= 32'h0000_0000;
		end
		else
		begin
			pready_ff <= apb_setup;
			pslverr_ff <= 1'b0;
			prdata_ff <= 32'h0000_0000;
			if (apb_setup)
			begin
				case (paddr)
					`MFCR_OFF_DFSR:
						prdata_ff <= {24'h000000, dfsr_ff};
					`MFCR_OFF_IFSR:
						prdata_ff <= {24'h000000, ifsr_ff};
					`MFCR_OFF_FAR:
						prdata_ff <= fault_addr_reg_ff;
					`MFCR_OFF_DACR:
						prdata_ff <= dacr_ff;
					`MFCR_OFF_CTRL:
						prdata_ff <= {28'h0000000, ctrl_ff};
					default:
						pslverr_ff <= 1'b1; // Unmapped offsets answer with an error
				endcase
			end
		end
	end

	// Software control and domain registers
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			ctrl_ff <= `MFCR_RST_CTRL;
			dacr_ff <= `MFCR_RST_DACR;
		end
		else
		begin
			if (wr_ctrl)
				ctrl_ff <= pwdata[`MFCR_CTRL_W-1:0];
			if (wr_dacr)
				dacr_ff <= pwdata;
		end
	end

	// Verdict back to the core one cycle after the request
	// The verdict holds between requests so the core may take it late
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			rsp_valid_ff <= 1'b0;
			rsp_ff <= '0;
		end
		else
		begin
			rsp_valid_ff <= chk_valid;
			if (chk_valid)
			begin
				rsp_ff.abort <= chk_abort;
				rsp_ff.bus_ok <= !chk_abort;
				rsp_ff.status <= chk_abort ? chk_status : 4'h0;
				rsp_ff.domain <= chk_dom_valid ? chk_req.l1_domain : 4'h0;
			end
		end
	end

	// Tracks whether the current multi-word transfer has already faulted
	// A lone word or a fresh first word restarts the tracking
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			burst_aborted_ff <= 1'b0;
		else if (chk_valid && !chk_req.is_fetch && !chk_req.is_pf_op)
		begin
			if (chk_req.burst_first || !chk_req.burst_more)
				burst_aborted_ff <= chk_abort;
			else if (chk_abort)
				burst_aborted_ff <= 1'b1;
		end
	end

	// Data fault status: check faults outrank bus external aborts, and hardware beats software
	// An invalid domain leaves the stored domain field as it was
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			dfsr_ff <= `MFCR_RST_FSR;
		else if (chk_capture && !chk_req.is_fetch && !chk_req.is_pf_op)
		begin
			dfsr_ff[`MFCR_FSR_STAT_LSB +: 4] <= chk_status;
			if (chk_dom_valid)
				dfsr_ff[`MFCR_FSR_DOM_LSB +: 4] <= chk_req.l1_domain;
		end
		else if (xab_valid)
		begin
			dfsr_ff[`MFCR_FSR_STAT_LSB +: 4] <= xab.is_section ? `MFCR_ST_XA_SEC : `MFCR_ST_XA_PAGE;
			dfsr_ff[`MFCR_FSR_DOM_LSB +: 4] <= xab.domain;
		end
		else if (wr_dfsr)
			dfsr_ff <= pwdata[`MFCR_FSR_W-1:0];
	end

	// Instruction fault status, also fed by explicit prefetch operations
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			ifsr_ff <= `MFCR_RST_FSR;
		else if (chk_capture && (chk_req.is_fetch || chk_req.is_pf_op))
		begin
			ifsr_ff[`MFCR_FSR_STAT_LSB +: 4] <= chk_status;
			if (chk_dom_valid)
				ifsr_ff[`MFCR_FSR_DOM_LSB +: 4] <= chk_req.l1_domain;
		end
		else if (wr_ifsr)
			ifsr_ff <= pwdata[`MFCR_FSR_W-1:0];
	end

	// Fault address: data aborts only; fetch faults never touch it
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			fault_addr_reg_ff <= `MFCR_RST_FAR;
		else if (chk_capture && !chk_req.is_fetch && !chk_req.is_pf_op)
			fault_addr_reg_ff <= chk_req.modified_virtual_address;
		else if (xab_valid)
			fault_addr_reg_ff <= xab_addr;
		else if (wr_far)
			fault_addr_reg_ff <= pwdata;
	end

endmodule

`default_nettype wire

//--- bench/mfcr_core_sva.sv
// Port-level checker for the access fault checker
`timescale 1ns/1ps
`default_nettype none
module mfcr_core_sva
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic chk_valid,
	input wire mfcr_pkg::mfcr_req_s chk_req,
	input wire logic rsp_valid,
	input wire mfcr_pkg::mfcr_rsp_s rsp,
	input wire logic xab_valid,
	input wire mfcr_pkg::mfcr_xab_s xab
);
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);
	// Every check gets exactly one verdict, one cycle later
	a_rsp_one_later: assert property (chk_valid |=> rsp_valid) else $error("no verdict");
	a_rsp_has_cause: assert property (rsp_valid |-> $past(chk_valid)) else $error("stray verdict");
	a_bus_blocked: assert property (rsp_valid |-> rsp.bus_ok != rsp.abort) else $error("bus pass");
	a_fetch_no_align: assert property (chk_valid && chk_req.is_fetch |=> rsp.status != 4'h1)
		else $error("fetch alignment");
	a_byte_no_align: assert property (chk_valid && chk_req.size == 2'h0 |=> rsp.status != 4'h1)
		else $error("byte alignment");
	a_invalid_dom: assert property (rsp_valid && rsp.status inside {4'h1, 4'h5, 4'hC} |-> rsp.domain == 4'h0)
		else $error("domain not cleared");
	a_valid_dom: assert property (chk_valid ##1 (rsp.status >= 4'h6 && rsp.status != 4'hC)
		|-> rsp.domain == $past(chk_req.l1_domain)) else $error("domain lost");
	a_verdict_hold: assert property (!rsp_valid |-> $stable(rsp)) else $error("verdict moved");
	a_apb_answer: assert property (psel && !penable |=> pready) else $error("no ready");
	a_apb_ready_src: assert property (pready |-> $past(psel && !penable) && penable) else $error("ready stray");
endmodule
bind mfcr_core mfcr_core_sva u_sva(.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
	.pready, .pslverr, .chk_valid, .chk_req, .rsp_valid, .rsp, .xab_valid, .xab);
`default_nettype wire

//--- bench/mfcr_cpu_model.sv
// Core-side model that issues access checks and keeps the last verdict
`timescale 1ns/1ps
`default_nettype none
module mfcr_cpu_model
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic go,
	input wire mfcr_pkg::mfcr_req_s req_in,
	output logic chk_valid,
	output mfcr_pkg::mfcr_req_s chk_req,
	input wire logic rsp_valid,
	input wire mfcr_pkg::mfcr_rsp_s rsp,
	output logic got,
	output mfcr_pkg::mfcr_rsp_s last
);
	// Idle request lines toggle so a stale value is never mistaken for a request
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			chk_valid <= 1'b0;
			chk_req <= '0;
		end
		else
		begin
			chk_valid <= go;
			chk_req <= go ? req_in : ~chk_req;
		end
	end
	// Verdict taken in the cycle it stands
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			got <= 1'b0;
			last <= '0;
		end
		else
		begin
			got <= rsp_valid;
			if (rsp_valid)
				last <= rsp;
		end
	end
endmodule
`default_nettype wire

//--- bench/testbench.sv
// Self-checking bench for the access fault checker
`timescale 1ns/1ps
`default_nettype none
`include "mfcr_map.svh"
module testbench;
	logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr, se;
	logic [11:0] paddr = '0;
	logic [31:0] pwdata = '0, prdata, q, far_e;
	logic chk_valid, rsp_valid, go = 0, got, xab_valid = 0, bab;
	mfcr_pkg::mfcr_req_s chk_req, rq, r;
	mfcr_pkg::mfcr_rsp_s rsp, last;
	mfcr_pkg::mfcr_xab_s xab = '0;
	logic [3:0] ctl_e;
	logic [31:0] dacr_e;
	logic [7:0] dfsr_e, ifsr_e;
	int failures = 0, cmp_count = 0;
	always #25 pclk = ~pclk;
	mfcr_core i_dut(.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
		.chk_valid, .chk_req, .rsp_valid, .rsp, .xab_valid, .xab);
	mfcr_cpu_model i_cpu(.pclk, .presetn, .go, .req_in(rq), .chk_valid, .chk_req, .rsp_valid, .rsp, .got, .last);
	task automatic summarize;
		$display("comparisons %0d mismatches %0d", cmp_count, failures);
		if (failures == 0 && cmp_count > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
		cmp_count++;
		if (s !== e)
		begin
			failures++;
			$display("[ERR] %s expected %h seen %h", nm, e, s);
		end
	endtask
	// APB transfer; pready, read data and error are all taken at the rising edge that completes it
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] o);
		int n;
		psel <= 1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1;
		n = 0;
		do begin @(posedge pclk); n++; end while (pready !== 1'b1 && n < 9);
		if (n >= 9)
		begin
			failures++;
			summarize();
		end
		o = prdata;
		se = pslverr;
		psel <= 0;
		penable <= 0;
		@(posedge pclk);
	endtask
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		apb(1, a, d, q);
		if (a == `MFCR_OFF_CTRL) ctl_e = d[3:0];
		if (a == `MFCR_OFF_DACR) dacr_e = d;
	endtask
	// Expected {abort, status} for one access
	function automatic logic [4:0] expf(input mfcr_pkg::mfcr_req_s x);
		logic sec, ok;
		logic [1:0] d, ap;
		sec = x.l1_type == 2'h2;
		d = dacr_e[2*x.l1_domain +: 2];
		ap = sec ? x.l1_ap : x.l2_ap;
		ok = ap == 2'h3 || (ap == 2'h1 && !x.is_user) || (ap == 2'h2 && !(x.is_user && x.is_write))
			|| (ap == 2'h0 && !x.is_write && (ctl_e[2] ^ ctl_e[3]));
		if (ctl_e[1] && !x.is_fetch && !x.is_pf_op && ((x.size == 2'h1 && x.modified_virtual_address[0]) || (x.size == 2'h2 && x.modified_virtual_address[1:0] != 2'h0)))
			return 5'h11;
		if (!ctl_e[0]) return 5'h00;
		if (x.l1_walk_abort) return 5'h1C;
		if (x.l1_type == 2'h0) return 5'h15;
		if (!sec && x.l2_walk_abort) return 5'h1E;
		if (!sec && x.l2_type == 2'h0) return 5'h17;
		if (!d[0]) return sec ? 5'h19 : 5'h1B;
		if (d == 2'h3 || ok) return 5'h00;
		return sec ? 5'h1D : 5'h1F;
	endfunction
	// One check through the core model, then the fault registers read back
	task automatic acc(input mfcr_pkg::mfcr_req_s x);
		logic [4:0] e;
		logic [3:0] dm;
		logic dv;
		int n;
		e = expf(x);
		dv = e[3:0] >= 4'h6 && e[3:0] != 4'hC;
		dm = dv ? x.l1_domain : 4'h0;
		go <= 1;
		rq <= x;
		@(posedge pclk);
		go <= 0;
		n = 0;
		do begin @(negedge pclk); n++; end while (got !== 1'b1 && n < 9);
		if (n >= 9)
		begin
			failures++;
			summarize();
		end
		chk("abort", {31'h0, last.abort}, {31'h0, e[4]});
		chk("status", {28'h0, last.status}, {28'h0, e[3:0]});
		chk("domain", {28'h0, last.domain}, {28'h0, dm});
		if (e[4] && (x.is_fetch || x.is_pf_op))
			ifsr_e = {dv ? x.l1_domain : ifsr_e[7:4], e[3:0]};
		else if (e[4] && !(x.burst_more && bab))
		begin
			dfsr_e = {dv ? x.l1_domain : dfsr_e[7:4], e[3:0]};
			far_e = x.modified_virtual_address;
		end
		if (!x.is_fetch && !x.is_pf_op)
			bab = (x.burst_first || !x.burst_more) ? e[4] : (bab | e[4]);
		@(posedge pclk);
		apb(0, `MFCR_OFF_DFSR, 0, q); chk("dfsr", q, {24'h0, dfsr_e});
		apb(0, `MFCR_OFF_IFSR, 0, q); chk("ifsr", q, {24'h0, ifsr_e});
		apb(0, `MFCR_OFF_FAR, 0, q); chk("far", q, far_e);
	endtask
	// External abort on a granted transfer
	task automatic xa(input logic sc, input logic [31:0] s, input logic [31:0] a, input logic [31:0] l);
		xab_valid <= 1;
		xab <= {sc, 4'h6, s, a, l};
		@(posedge pclk);
		xab_valid <= 0;
		@(posedge pclk);
		dfsr_e = {4'h6, sc ? 4'h8 : 4'hA};
		far_e = (a[31:10] == s[31:10] && l[31:10] != s[31:10]) ? {s[31:10], 10'h3FC} : l;
		apb(0, `MFCR_OFF_DFSR, 0, q); chk("xdfsr", q, {24'h0, dfsr_e});
		apb(0, `MFCR_OFF_FAR, 0, q); chk("xfar", q, far_e);
	endtask
	initial
	begin
		{ctl_e, dacr_e, dfsr_e, ifsr_e, far_e, bab} = '0;
		rq = '0;
		repeat (8) @(posedge pclk);
		presetn <= 1;
		void'($urandom(77));
		@(posedge pclk);
		for (int i = 0; i < 5; i++)
		begin
			apb(0, 12'(4 * i), 0, q); chk("reset", q, 0);
		end
		apb(0, 12'h014, 0, q); chk("slverr", {31'h0, se}, 1);
		// Directed: priority, retry, client, manager, fetch, prefetch op, burst
		wr(`MFCR_OFF_CTRL, 32'h3);
		r = '0;
		r.l1_type = 2'h2;
		r.l1_domain = 4'h5;
		r.size = 2'h2;
		r.modified_virtual_address = 32'h0000_1002;
		acc(r);
		r.modified_virtual_address = 32'h0000_1000;
		acc(r);
		wr(`MFCR_OFF_DACR, 32'h400);
		r.is_user = 1;
		r.l1_ap = 2'h1;
		acc(r);
		r.is_fetch = 1;
		r.l1_type = 2'h0;
		acc(r);
		r.is_fetch = 0;
		r.is_pf_op = 1;
		acc(r);
		wr(`MFCR_OFF_DACR, 32'hC00);
		r = '0;
		r.l1_domain = 4'h5;
		r.l1_type = 2'h2;
		r.burst_first = 1;
		r.modified_virtual_address = 32'h100;
		acc(r);
		r.burst_first = 0;
		r.burst_more = 1;
		r.l1_type = 2'h0;
		for (int i = 1; i < 3; i++)
		begin
			r.modified_virtual_address = 32'h100 + 32'(4 * i);
			acc(r);
		end
		xa(1, 32'h0000_23F0, 32'h0000_23F4, 32'h0000_2408);
		xa(0, 32'h0000_23F0, 32'h0000_2404, 32'h0000_2408);
		// Random accesses under random controls
		for (int k = 0; k < 12; k++)
		begin
			wr(`MFCR_OFF_DACR, $urandom);
			wr(`MFCR_OFF_CTRL, $urandom | (k > 1));
			apb(0, `MFCR_OFF_DACR, 0, q); chk("dacr", q, dacr_e);
			repeat (20)
			begin
				r = mfcr_pkg::mfcr_req_s'(54'({$urandom, $urandom}));
				if (r.size == 2'h3) r.size = 2'h2;
				if (r.is_fetch) r.is_pf_op = 0;
				r.burst_first = 0;
				r.burst_more = 0;
				acc(r);
			end
		end
		summarize();
	end
endmodule
`default_nettype wire
